//--- izcs_pkg.sv
// Package for the impedance calibration sequencer: register map, field positions,
// reset values, timing counts and the carrier types shared by the design files.
// Assumes a single 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package izcs_pkg;

    // Clock period in picoseconds at 250 MHz.
    localparam int CLK_PERIOD_PS = 4000;

    // Calibration time is a least time, so the cycle count rounds up.
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_CNT_W = 9;
    localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

    // Width of one driver impedance code.
    localparam int CODE_W = 8;
    // Code loaded by system reset into the drivers and the default register: the untrimmed, plus or minus 30 percent setting.
    localparam logic [CODE_W-1:0] DEFAULT_CODE_RST = 8'h20;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DEFAULT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_LAST_CODE = 8'h0c;
    localparam logic [7:0] OFS_CH0_CODE = 8'h10;
    localparam logic [7:0] OFS_CH1_CODE = 8'h14;
    localparam int ADDR_W = 8;

    // Control register fields (write one to act, read as zero).
    localparam int CTRL_SW_START = 0;
    localparam int CTRL_SW_RESET0 = 1;
    localparam int CTRL_SW_RESET1 = 2;

    // Status register fields.
    localparam int ST_BUSY = 0;
    localparam int ST_RESULT_VALID = 1;
    localparam int ST_IGNORED = 2;
    localparam int ST_EARLY_LATCH = 3;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Number of channels on the die.
    localparam int NUM_CH = 2;

    // Decoded register selector.
    typedef enum logic [2:0] {
        REG_CTRL,
        REG_DEFAULT,
        REG_STATUS,
        REG_LAST_CODE,
        REG_CH0_CODE,
        REG_CH1_CODE,
        REG_NONE
    } izcs_reg_type;

    // Decoded calibration commands of one channel, one-cycle pulses.
    typedef struct packed {
        logic start;
        logic latch;
        logic cal_reset;
    } izcs_cmd_type;

    // Report from the shared engine.
    typedef struct packed {
        logic busy;
        logic done;
        logic ignored;
        logic valid;
        logic [CODE_W-1:0] code;
    } izcs_eng_type;

endpackage

//--- izcs_engine.sv
// Shared calibration engine: one per die, serving both channels.
// Assumes start requests are one-cycle pulses and that the measured code from the
// analog comparator is stable when the calibration time has run out.
`timescale 1ns/1ps
module izcs_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_req,
    input wire logic [izcs_pkg::CODE_W-1:0] measure_code,
    output izcs_pkg::izcs_eng_type report
);

    typedef enum logic {ENG_IDLE, ENG_RUN} izcs_eng_state_type;

    izcs_eng_state_type state_q;
    logic [izcs_pkg::CAL_CNT_W-1:0] cnt_q;
    logic [izcs_pkg::CODE_W-1:0] code_q;
    logic valid_q;
    logic done_q;
    logic ignored_q;

    // start ignored
    // A start while running is only reported; the run and its count go on untouched.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ignored_q <= 1'b0;
        end else begin
            ignored_q <= start_req && (state_q == ENG_RUN);
        end
    end

    // busy flag
    // The run state is the in-progress flag; it lasts exactly the calibration time.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ENG_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                ENG_IDLE: begin
                    if (start_req) begin
                        state_q <= ENG_RUN;
                        cnt_q <= '0;
                    end
                end
                ENG_RUN: begin
                    if (cnt_q == izcs_pkg::CAL_LAST) begin
                        state_q <= ENG_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // single result
    // The completed code changes only at the end of a run, so a reader during a run
    // still sees the previous result.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_q <= izcs_pkg::DEFAULT_CODE_RST;
            valid_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (state_q == ENG_RUN && cnt_q == izcs_pkg::CAL_LAST) begin
                code_q <= measure_code;
                valid_q <= 1'b1;
                done_q <= 1'b1;
            end
        end
    end

    // Report assembled from flip-flops only.
    always_comb begin
        report.busy = (state_q == ENG_RUN);
        report.done = done_q;
        report.ignored = ignored_q;
        report.valid = valid_q;
        report.code = code_q;
    end

endmodule

//--- izcs_top.sv
// Top of the impedance calibration sequencer: per-channel command handling, the
// per-channel driver codes and the AXI4-Lite register slave.
// Assumes channel commands arrive already decoded as one-cycle pulses synchronous
// to SYS_CLK, and that the controller keeps its own timing and power-down duties.
// None of those duties is checked here: a latch that comes too soon is carried out
// as it stands and flagged only by the early-latch status bit; a command during a
// settle time is carried out as it stands and not flagged.
//
// Behaviour
// - start begins calibration; latch loads the result into that channel's drivers.
// - calibration reset write returns channel to the default code held in the software-trimmed default register.
// - one engine makes the values, both channels use them.
// - starts accepted from either or both channels, anytime, other commands continue.
// - start arriving during a running calibration is ignored, run continues.
// - latch after calibration time loads result of the most recent start that was not ignored.
// - latch before calibration time loads most recently completed result.
// - calibration reset affects only the issuing channel.
// - each channel can send starts independently.
`timescale 1ns/1ps
module izcs_top (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input izcs_pkg::izcs_cmd_type [izcs_pkg::NUM_CH-1:0] CAL_CMD,
    input wire logic [izcs_pkg::CODE_W-1:0] CAL_MEASURE_CODE,
    output logic [izcs_pkg::CODE_W-1:0] DRV_CODE_CH0,
    output logic [izcs_pkg::CODE_W-1:0] DRV_CODE_CH1,
    output logic CAL_BUSY,
    input wire logic [izcs_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [izcs_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // Register selector shared by the read and write paths.
    function automatic izcs_pkg::izcs_reg_type decode_reg(input logic [izcs_pkg::ADDR_W-1:0] addr);
        izcs_pkg::izcs_reg_type sel;
        sel = izcs_pkg::REG_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr)
                izcs_pkg::OFS_CTRL: sel = izcs_pkg::REG_CTRL;
                izcs_pkg::OFS_DEFAULT: sel = izcs_pkg::REG_DEFAULT;
                izcs_pkg::OFS_STATUS: sel = izcs_pkg::REG_STATUS;
                izcs_pkg::OFS_LAST_CODE: sel = izcs_pkg::REG_LAST_CODE;
                izcs_pkg::OFS_CH0_CODE: sel = izcs_pkg::REG_CH0_CODE;
                izcs_pkg::OFS_CH1_CODE: sel = izcs_pkg::REG_CH1_CODE;
                default: sel = izcs_pkg::REG_NONE;
            endcase
        end
        return sel;
    endfunction

    // Register map, one aligned word each, with every field in byte lane 0.
    // Control, write one to act: software start, channel 0 reset, channel 1 reset.
    // It always reads as zero.
    // Default code, read and write, loaded into a channel by its reset.
    // Status: busy and result valid follow the engine; ignored start and early
    // latch are sticky and cleared by writing one.
    // Last completed code, then the channel 0 and channel 1 driver codes, read only.
    // Any other address answers with a slave error and has no effect.

    // Write channel state.
    logic aw_held_q;
    logic w_held_q;
    logic [izcs_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    izcs_pkg::izcs_reg_type wr_sel;

    // Read channel state.
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    izcs_pkg::izcs_reg_type rd_sel;

    // Software controlled state.
    logic [izcs_pkg::CODE_W-1:0] default_code_q;
    logic ignored_q;
    logic early_latch_q;
    logic sw_start;
    logic [izcs_pkg::NUM_CH-1:0] sw_reset;
    logic clr_ignored;
    logic clr_early;

    // Calibration state.
    logic [izcs_pkg::CODE_W-1:0] drv_code_q [izcs_pkg::NUM_CH];
    logic start_any;
    logic [izcs_pkg::NUM_CH-1:0] early_hit;
    izcs_pkg::izcs_eng_type eng;

    // Address and data are each held until both are present; no new write is
    // taken while a response waits, so at most one write is in flight.
    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel = decode_reg(awaddr_q);

    // Capture of write address and write data, in either order.
    // A held item is dropped only when the write is carried out, so an address
    // that arrives long before its data is not lost.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    // Any high BREADY clears the response, so a master that holds it up from the
    // start sees the response for exactly one cycle.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            bvalid_q <= 1'b0;
            bresp_q <= izcs_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == izcs_pkg::REG_NONE) ? izcs_pkg::RESP_SLVERR : izcs_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    // Write-one actions; only byte lane 0 carries them.
    // Writes to read-only registers are answered with OKAY and change nothing, so
    // software cannot preload a driver code, only reset it to the default code.
    always_comb begin
        sw_start = 1'b0;
        sw_reset = '0;
        clr_ignored = 1'b0;
        clr_early = 1'b0;
        if (do_write && wstrb_q[0]) begin
            if (wr_sel == izcs_pkg::REG_CTRL) begin
                sw_start = wdata_q[izcs_pkg::CTRL_SW_START];
                sw_reset[0] = wdata_q[izcs_pkg::CTRL_SW_RESET0];
                sw_reset[1] = wdata_q[izcs_pkg::CTRL_SW_RESET1];
            end
            if (wr_sel == izcs_pkg::REG_STATUS) begin
                clr_ignored = wdata_q[izcs_pkg::ST_IGNORED];
                clr_early = wdata_q[izcs_pkg::ST_EARLY_LATCH];
            end
        end
    end

    // Default code used by calibration resets; trimmed by software per die.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            default_code_q <= izcs_pkg::DEFAULT_CODE_RST;
        end else if (do_write && wstrb_q[0] && wr_sel == izcs_pkg::REG_DEFAULT) begin
            default_code_q <= wdata_q[izcs_pkg::CODE_W-1:0];
        end
    end

    // per-channel starts
    // Starts from both channels and software merge into one request; simultaneous
    // starts thus launch one run, and other commands are never stalled.
    // Software starts obey the same ignore rule as channel starts.
    assign start_any = CAL_CMD[0].start || CAL_CMD[1].start || sw_start;

    // start launches engine
    // The engine is shared and ignores calibration resets, so a reset on one
    // channel never disturbs a run that the other channel started.
    izcs_engine u_engine (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .start_req(start_any),
        .measure_code(CAL_MEASURE_CODE),
        .report(eng)
    );

    // Busy is the engine's run state, taken straight from its flip-flop, so it
    // rises at the edge that samples the start, one cycle after the start appears.
    assign CAL_BUSY = eng.busy;

    // Per-channel driver code registers, one per channel.
    // The codes are levels that stand until the next latch or reset of the same
    // channel; the drivers are expected to follow them without a strobe.
    genvar ch;
    generate
        for (ch = 0; ch < izcs_pkg::NUM_CH; ch++) begin : g_chan
            // latch before time
            // While a run is active the engine still holds the last completed code,
            // so one path serves both cases. A latch sampled in the last busy cycle
            // still takes the old code, as the run has not yet met its time; from
            // the next cycle on the new code stands in the engine's register.
            assign early_hit[ch] = CAL_CMD[ch].latch && eng.busy;

            // reset own channel
            // A reset and a latch in the same cycle: the reset is tested first and wins.
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    drv_code_q[ch] <= izcs_pkg::DEFAULT_CODE_RST;
                end else if (CAL_CMD[ch].cal_reset || sw_reset[ch]) begin
                    drv_code_q[ch] <= default_code_q;
                end else if (CAL_CMD[ch].latch) begin
                    drv_code_q[ch] <= eng.code;
                end
            end
        end
    endgenerate

    assign DRV_CODE_CH0 = drv_code_q[0];
    assign DRV_CODE_CH1 = drv_code_q[1];

    // ignored start noted
    // Sticky status events; a new event in the clearing cycle survives the clear.
    // The engine reports an ignored start one edge late, so software may see busy
    // drop before the ignored bit rises.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ignored_q <= 1'b0;
            early_latch_q <= 1'b0;
        end else begin
            ignored_q <= (ignored_q && !clr_ignored) || eng.ignored;
            early_latch_q <= (early_latch_q && !clr_early) || (|early_hit);
        end
    end

    // Read path: one outstanding read, answered the cycle after it is taken.
    // The address is decoded straight from the bus, so the data show the registers
    // as they stand at the taking edge; a write landing at that same edge is not
    // yet visible to the read.
    assign S_AXI_ARREADY = !rvalid_q;
    assign rd_sel = decode_reg(S_AXI_ARADDR);

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= izcs_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rresp_q <= izcs_pkg::RESP_OKAY;
            rdata_q <= '0;
            unique case (rd_sel)
                izcs_pkg::REG_CTRL: rdata_q <= '0;
                izcs_pkg::REG_DEFAULT: rdata_q[izcs_pkg::CODE_W-1:0] <= default_code_q;
                izcs_pkg::REG_STATUS: begin
                    rdata_q[izcs_pkg::ST_BUSY] <= eng.busy;
                    rdata_q[izcs_pkg::ST_RESULT_VALID] <= eng.valid;
                    rdata_q[izcs_pkg::ST_IGNORED] <= ignored_q;
                    rdata_q[izcs_pkg::ST_EARLY_LATCH] <= early_latch_q;
                end
                izcs_pkg::REG_LAST_CODE: rdata_q[izcs_pkg::CODE_W-1:0] <= eng.code;
                izcs_pkg::REG_CH0_CODE: rdata_q[izcs_pkg::CODE_W-1:0] <= drv_code_q[0];
                izcs_pkg::REG_CH1_CODE: rdata_q[izcs_pkg::CODE_W-1:0] <= drv_code_q[1];
                izcs_pkg::REG_NONE: rresp_q <= izcs_pkg::RESP_SLVERR;
            endcase
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

endmodule

//--- izcs_top_sva.sv
// Assertion checker for the calibration sequencer top.
// Assumes it is bound to izcs_top and sees only that module's ports.
`timescale 1ns/1ps
module izcs_top_sva (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input izcs_pkg::izcs_cmd_type [izcs_pkg::NUM_CH-1:0] CAL_CMD,
    input wire logic [izcs_pkg::CODE_W-1:0] CAL_MEASURE_CODE,
    input logic [izcs_pkg::CODE_W-1:0] DRV_CODE_CH0,
    input logic [izcs_pkg::CODE_W-1:0] DRV_CODE_CH1,
    input logic CAL_BUSY,
    input logic S_AXI_BVALID
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    logic [8:0] busy_cnt_q;
    logic [7:0] done_code_q;
    logic any_start;
    assign any_start = CAL_CMD[0].start | CAL_CMD[1].start;
    // Count busy cycles; a long repetition would slow the tools badly.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            busy_cnt_q <= 9'h000;
        end else begin
            busy_cnt_q <= CAL_BUSY ? busy_cnt_q + 9'h001 : 9'h000;
        end
    end
    // Shadow of the last completed code, taken in the final busy cycle.
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            done_code_q <= izcs_pkg::DEFAULT_CODE_RST;
        end else if (CAL_BUSY && busy_cnt_q == 9'(izcs_pkg::CAL_CYCLES - 1)) begin
            done_code_q <= CAL_MEASURE_CODE;
        end
    end
    a_start_sets_busy: assert property (!CAL_BUSY && any_start |=> CAL_BUSY)
        else $error("start did not raise busy");
    a_busy_rise_cause: assert property ($rose(CAL_BUSY) |-> $past(any_start) || $rose(S_AXI_BVALID))
        else $error("busy rose without a start");
    a_busy_max_len: assert property (CAL_BUSY |-> busy_cnt_q < 9'(izcs_pkg::CAL_CYCLES))
        else $error("busy run too long");
    a_busy_exact_len: assert property ($fell(CAL_BUSY) |-> $past(busy_cnt_q) == 9'(izcs_pkg::CAL_CYCLES - 1))
        else $error("busy run length wrong");
    a_latch_ch0_code: assert property (CAL_CMD[0].latch && !CAL_CMD[0].cal_reset |=> DRV_CODE_CH0 == $past(done_code_q))
        else $error("channel 0 latched a wrong code");
    a_latch_ch1_code: assert property (CAL_CMD[1].latch && !CAL_CMD[1].cal_reset |=> DRV_CODE_CH1 == $past(done_code_q))
        else $error("channel 1 latched a wrong code");
    a_reset_spares_ch1: assert property (CAL_CMD[0].cal_reset && !CAL_CMD[1].latch && !CAL_CMD[1].cal_reset
        |=> $stable(DRV_CODE_CH1))
        else $error("channel 0 reset disturbed channel 1");
    a_reset_spares_ch0: assert property (CAL_CMD[1].cal_reset && !CAL_CMD[0].latch && !CAL_CMD[0].cal_reset
        |=> $stable(DRV_CODE_CH0))
        else $error("channel 1 reset disturbed channel 0");
    a_code_change_cause: assert property ($changed(DRV_CODE_CH0)
        |-> $past(CAL_CMD[0].latch | CAL_CMD[0].cal_reset) || $rose(S_AXI_BVALID))
        else $error("channel 0 code changed unprompted");
    c_ignored_start: cover property (CAL_BUSY && any_start);
    c_early_latch: cover property (CAL_BUSY && CAL_CMD[0].latch);
    c_both_latch: cover property (CAL_CMD[0].latch && CAL_CMD[1].latch);
    c_cal_reset: cover property (CAL_CMD[1].cal_reset);
endmodule

bind izcs_top izcs_top_sva u_sva (
    .SYS_CLK(SYS_CLK),
    .RSTN(RSTN),
    .CAL_CMD(CAL_CMD),
    .CAL_MEASURE_CODE(CAL_MEASURE_CODE),
    .DRV_CODE_CH0(DRV_CODE_CH0),
    .DRV_CODE_CH1(DRV_CODE_CH1),
    .CAL_BUSY(CAL_BUSY),
    .S_AXI_BVALID(S_AXI_BVALID)
);

//--- izcs_ctrl_model.sv
// Memory controller model issuing decoded calibration commands.
// Assumes the bench calls its tasks; every command is a one-cycle pulse.
`timescale 1ns/1ps
module izcs_ctrl_model (
    input wire logic clk,
    input wire logic rst_n,
    output izcs_pkg::izcs_cmd_type [izcs_pkg::NUM_CH-1:0] cmd
);
    // Settle times rounded up to whole 4 ns cycles.
    localparam int LAT_CYC = 8;
    localparam int RST_CYC = 13;
    int cyc = 0;
    int t_start = 0;
    initial cmd = '0;
    // Free cycle count that times the calibration window.
    always @(posedge clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
    end
    // no power-down, no mode writes, single die.
    task automatic pulse(input logic [1:0] st, input logic [1:0] lt, input logic [1:0] rs);
        @(posedge clk);
        cmd[0] <= {st[0], lt[0], rs[0]};
        cmd[1] <= {st[1], lt[1], rs[1]};
        @(posedge clk);
        cmd <= '0;
    endtask
    task automatic start(input logic [1:0] m);
        pulse(m, 2'b00, 2'b00);
        t_start = cyc;
    endtask
    // wait calibration time, unless early asked.
    task automatic latch(input logic [1:0] m, input logic early);
        while (!early && cyc - t_start < izcs_pkg::CAL_CYCLES) begin
            @(posedge clk);
        end
        pulse(2'b00, m, 2'b00);
        repeat (LAT_CYC) @(posedge clk);
    endtask
    task automatic cal_reset(input logic [1:0] m);
        pulse(2'b00, 2'b00, m);
        repeat (RST_CYC) @(posedge clk);
    endtask
endmodule

//--- tb_impedance_calibration_sequencer.sv
// Self-checking bench for the calibration sequencer.
// Assumes the controller model drives the commands and the bench the register bus.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("BAD %0t got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_impedance_calibration_sequencer;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] meas = 8'h00;
    logic [7:0] aw_a = 8'h00;
    logic [7:0] ar_a = 8'h00;
    logic [31:0] w_d = 32'h0;
    logic [3:0] w_s = 4'hf;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic b_r = 1'b0;
    logic ar_v = 1'b0;
    logic r_r = 1'b0;
    izcs_pkg::izcs_cmd_type [1:0] cmd;
    logic [7:0] drv0, drv1;
    logic busy, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    int mismatches = 0;
    int tests_run = 0;
    int nb;
    always #2 clk = ~clk;
    izcs_ctrl_model ctl (.clk(clk), .rst_n(rstn), .cmd(cmd));
    izcs_top dut (.SYS_CLK(clk), .RSTN(rstn), .CAL_CMD(cmd), .CAL_MEASURE_CODE(meas),
        .DRV_CODE_CH0(drv0), .DRV_CODE_CH1(drv1), .CAL_BUSY(busy),
        .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_r));
    // Requests change just after a rising edge; ready and answers are taken at rising edges.
    // Only the watchdog ends a wait, so a hung bus shows up as a timeout.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic hb;
        hb = 1'b0;
        @(posedge clk);
        aw_a <= a;
        aw_v <= 1'b1;
        w_d <= v;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!hb) begin
            @(posedge clk);
            if (aw_v && awready === 1'b1) aw_v <= 1'b0;
            if (w_v && wready === 1'b1) w_v <= 1'b0;
            hb = (bvalid === 1'b1);
            rs = bresp;
        end
        b_r <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic hr;
        hr = 1'b0;
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        while (!hr) begin
            @(posedge clk);
            if (ar_v && arready === 1'b1) ar_v <= 1'b0;
            hr = (rvalid === 1'b1);
            v = rdata;
            rs = rresp;
        end
        r_r <= 1'b0;
    endtask
    // Counts busy cycles and returns once busy has dropped, or after 400 cycles.
    task automatic count_busy(output int c);
        int k;
        c = 0;
        for (k = 0; k < 400; k++) begin
            @(negedge clk);
            if (busy === 1'b1) c++;
            else if (c > 0) break;
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs about 870 cycles.
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK(drv0, 8'h20)
        `CHK(busy, 1'b0)
        axi_rd(izcs_pkg::OFS_DEFAULT, d, r);
        `CHK(d, 32'h00000020)
        // Early latch with no finished run, then a start while busy.
        meas <= 8'h5a;
        ctl.start(2'b01);
        fork
            count_busy(nb);
            begin
                ctl.latch(2'b10, 1'b1);
                `CHK(drv1, 8'h20)
                ctl.start(2'b10);
            end
        join
        `CHK(nb, izcs_pkg::CAL_CYCLES)
        axi_rd(izcs_pkg::OFS_STATUS, d, r);
        `CHK(d, 32'h0000000e)
        `CHK(r, izcs_pkg::RESP_OKAY)
        ctl.latch(2'b11, 1'b0);
        `CHK(drv0, 8'h5a)
        `CHK(drv1, 8'h5a)
        axi_wr(izcs_pkg::OFS_STATUS, 32'h0000000c, r);
        axi_rd(izcs_pkg::OFS_STATUS, d, r);
        `CHK(d, 32'h00000002)
        // Both channels start together; an early latch keeps the old code.
        meas <= 8'h3c;
        ctl.start(2'b11);
        ctl.latch(2'b01, 1'b1);
        `CHK(drv0, 8'h5a)
        ctl.latch(2'b01, 1'b0);
        `CHK(drv0, 8'h3c)
        `CHK(drv1, 8'h5a)
        axi_rd(izcs_pkg::OFS_LAST_CODE, d, r);
        `CHK(d, 32'h0000003c)
        // Per-channel resets.
        ctl.cal_reset(2'b01);
        `CHK(drv0, 8'h20)
        `CHK(drv1, 8'h5a)
        axi_wr(izcs_pkg::OFS_DEFAULT, 32'h00000011, r);
        ctl.cal_reset(2'b10);
        `CHK(drv1, 8'h11)
        `CHK(drv0, 8'h20)
        // Register-bus start, unmapped access and register reset.
        axi_wr(izcs_pkg::OFS_CTRL, 32'h00000001, r);
        axi_rd(izcs_pkg::OFS_STATUS, d, r);
        `CHK(d[0], 1'b1)
        axi_rd(8'h40, d, r);
        `CHK(r, izcs_pkg::RESP_SLVERR)
        `CHK(d, 32'h00000000)
        count_busy(nb);
        axi_wr(izcs_pkg::OFS_CTRL, 32'h00000002, r);
        `CHK(r, izcs_pkg::RESP_OKAY)
        `CHK(drv0, 8'h11)
        // Only byte lane 0 carries fields; channel 1 reset from the register bus.
        axi_wr(izcs_pkg::OFS_DEFAULT, 32'h00000033, r);
        w_s <= 4'he;
        axi_wr(izcs_pkg::OFS_DEFAULT, 32'h00000077, r);
        w_s <= 4'hf;
        axi_wr(izcs_pkg::OFS_CTRL, 32'h00000004, r);
        `CHK(drv1, 8'h33)
        `CHK(drv0, 8'h11)
        axi_wr(8'h40, 32'h00000001, r);
        `CHK(r, izcs_pkg::RESP_SLVERR)
        `CHK(busy, 1'b0)
        tally_and_finish();
    end
endmodule
